// [pmb_dev.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pmb_consts.svh"
// frame: cs high, msb first on scl rise: rw(1) cmd(8) data(16); read data out on sdo
module pmb_dev
    import pmb_pkg::*;
#(
    parameter int BUSY_CYCLES = `BUSY_CYC
) (
    input  wire logic core_clk,
    input  wire logic srst,
    pmb_if.dev        lnk,
    input  wire logic en_pin,
    input  wire logic fault_in,
    input  wire logic [15:0] strap_vtgt,
    input  wire logic [15:0] strap_fsw,
    output logic      [1:0]  out_on,
    output logic      [31:0] vout_set,
    output logic      alert_line
);
    // ****************************************
    // link sampling
    // ****************************************
    logic [2:0] scl_s_r, cs_s_r, sdi_s_r;
    always_ff @(posedge core_clk) begin
        scl_s_r <= {scl_s_r[1:0], lnk.scl};
        cs_s_r  <= {cs_s_r[1:0], lnk.cs};
        sdi_s_r <= {sdi_s_r[1:0], lnk.sdi};
    end
    logic [1:0] en_s_r;
    always_ff @(posedge core_clk) begin
        en_s_r <= {en_s_r[0], en_pin};
    end
    wire scl_rise = scl_s_r[1] & ~scl_s_r[2];
    wire cs_act   = cs_s_r[1];

    // ****************************************
    // frame shifter
    // ****************************************
    logic [24:0] sh_r;
    logic [4:0]  bits_r;
    logic        frame_done_r;
    logic [15:0] rd_sh_r;
    logic        busy_r;
    always_ff @(posedge core_clk) begin
        frame_done_r <= 1'b0;
        if (srst || !cs_act) begin
            if (!srst && bits_r == 5'd25) begin
                frame_done_r <= 1'b1;
            end
            bits_r <= 5'd0;
        end else if (scl_rise && bits_r != 5'd25) begin
            sh_r   <= {sh_r[23:0], sdi_s_r[1]};
            bits_r <= bits_r + 5'd1;
        end
    end

    // ****************************************
    // per-channel settings
    // ****************************************
    logic [7:0] chsel_r, ensrc_r;
    logic [7:0] oper_r [2];
    word_t vtgt_r [2], vtrim_r [2], vmax_r [2], vmhi_r [2], vmlo_r [2];
    word_t slew_r [2], slope_r [2], fsw_r [2], vramp_r [2];
    logic [127:0] user_r [2];            // user store, one packed record per channel
    logic [31:0] busy_cnt_r;
    logic        strap_done_r;
    wire  [7:0]  cmd  = sh_r[23:16];
    wire  word_t wdat = sh_r[15:0];
    wire         wr   = frame_done_r & ~sh_r[24] & ~busy_r;

    function automatic logic hits(input logic [7:0] sel, input int ch);
        hits = (sel == `CH_BOTH) || (sel[0] == ch[0]);
    endfunction
    function automatic word_t scale(input word_t v, input int num);
        logic [31:0] p;
        p = 32'(v) * 32'(num);
        scale = p[21:6];                   // num in 64ths
    endfunction
    function automatic logic op_ok(input logic [7:0] v);
        op_ok = v == `OP_OFF_NOW || v == `OP_OFF_SOFT || v == `OP_ON_NOM ||
                v == `OP_ON_LOW || v == `OP_ON_HIGH;
    endfunction

    // busy window for save/load commands; reset clears it, no window after reset
    always_ff @(posedge core_clk) begin
        if (srst) begin
            busy_cnt_r <= 32'd0;
            busy_r     <= 1'b0;
        end else if (wr && (cmd == `CMD_SAVE || cmd == `CMD_LOAD)) begin
            busy_cnt_r <= 32'(BUSY_CYCLES);
            busy_r     <= 1'b1;
        end else if (busy_cnt_r != 32'd0) begin
            busy_cnt_r <= busy_cnt_r - 32'd1;
        end else begin
            busy_r <= 1'b0;
        end
    end

    // settings; strapped defaults loaded once after reset (acts as power-up load)
    always_ff @(posedge core_clk) begin
        if (srst) begin
            chsel_r      <= `CH_ONE;
            ensrc_r      <= `SRC_PIN_NOW;
            strap_done_r <= 1'b0;
        end else begin
            strap_done_r <= 1'b1;
            if (wr && cmd == `CMD_CHSEL &&
                (wdat[7:0] == `CH_ONE || wdat[7:0] == `CH_TWO || wdat[7:0] == `CH_BOTH)) begin
                chsel_r <= wdat[7:0];
            end
            if (wr && cmd == `CMD_ENSRC &&
                (wdat[7:0] == `SRC_PIN_SOFT || wdat[7:0] == `SRC_PIN_NOW ||
                 wdat[7:0] == `SRC_CMD_SOFT || wdat[7:0] == `SRC_CMD_NOW)) begin
                ensrc_r <= wdat[7:0];
            end
        end
    end

    for (genvar c = 0; c < 2; c++) begin : g_ch
        wire sel = hits(chsel_r, c);
        wire on  = out_on[c];
        always_ff @(posedge core_clk) begin
            if (srst) begin
                oper_r[c]  <= `OP_OFF_NOW;
                vtrim_r[c] <= `TRIM_RST;
                slew_r[c]  <= `SLEW_RST;
            end else if (!strap_done_r) begin
                vtgt_r[c]  <= strap_vtgt;
                vmax_r[c]  <= scale(strap_vtgt, 70);   // 1.10
                vmhi_r[c]  <= scale(strap_vtgt, 67);   // 1.05
                vmlo_r[c]  <= scale(strap_vtgt, 61);   // 0.95
                fsw_r[c]   <= strap_fsw;
                slope_r[c] <= 16'h0000;
                // store starts from the straps; it does not outlive srst
                user_r[c]  <= {strap_vtgt, `TRIM_RST, scale(strap_vtgt, 70),
                               scale(strap_vtgt, 67), scale(strap_vtgt, 61), `SLEW_RST,
                               16'h0000, strap_fsw};
            end else if (wr && cmd == `CMD_SAVE) begin
                // save and load act on both channels whatever the select
                user_r[c]  <= {vtgt_r[c], vtrim_r[c], vmax_r[c], vmhi_r[c],
                               vmlo_r[c], slew_r[c], slope_r[c], fsw_r[c]};
            end else if (wr && cmd == `CMD_LOAD) begin
                {vtgt_r[c], vtrim_r[c], vmax_r[c], vmhi_r[c],
                 vmlo_r[c], slew_r[c], slope_r[c], fsw_r[c]} <= user_r[c];
            end else if (wr && sel) begin
                case (cmd)
                    `CMD_OPER:  if (op_ok(wdat[7:0])) oper_r[c] <= wdat[7:0];
                    `CMD_VTGT:  vtgt_r[c]  <= (wdat > vmax_r[c]) ? vmax_r[c] : wdat;
                    `CMD_VTRIM: vtrim_r[c] <= wdat;
                    `CMD_VMAX:  vmax_r[c]  <= wdat;
                    `CMD_VMHI:  vmhi_r[c]  <= wdat;
                    `CMD_VMLO:  vmlo_r[c]  <= wdat;
                    `CMD_SLEW:  slew_r[c]  <= wdat;
                    `CMD_SLOPE: if (!on) slope_r[c] <= wdat;
                    `CMD_FSW:   if (!on) fsw_r[c] <= wdat;
                    default: ;
                endcase
            end
        end
        // enable decision
        wire use_pin = ~ensrc_r[3];
        wire op_on   = oper_r[c][7];
        always_ff @(posedge core_clk) begin
            if (srst) begin
                out_on[c] <= 1'b0;
            end else begin
                out_on[c] <= use_pin ? en_s_r[1] : op_on;
            end
        end
        // goal voltage: margin pick, trim offset, ceiling cap
        word_t goal, capped;
        always_comb begin
            goal = vtgt_r[c];
            if (oper_r[c] == `OP_ON_LOW)  goal = vmlo_r[c];
            if (oper_r[c] == `OP_ON_HIGH) goal = vmhi_r[c];
            goal   = goal + vtrim_r[c];
            capped = (goal > vmax_r[c]) ? vmax_r[c] : goal;
        end
        // ramp toward goal; fastest code jumps directly
        always_ff @(posedge core_clk) begin
            if (srst) begin
                vramp_r[c] <= 16'h0000;
            end else if (slew_r[c] == `SLEW_FAST) begin
                vramp_r[c] <= capped;
            end else if (vramp_r[c] < capped) begin
                vramp_r[c] <= vramp_r[c] + `SLEW_STEP;
            end else if (vramp_r[c] > capped) begin
                vramp_r[c] <= vramp_r[c] - `SLEW_STEP;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        vout_set <= {vramp_r[1], vramp_r[0]};
    end

    // fault latch; live fault re-sets at once
    always_ff @(posedge core_clk) begin
        if (srst) begin
            alert_line <= 1'b0;
        end else if (fault_in) begin
            alert_line <= 1'b1;
        end else if (wr && cmd == `CMD_CLRF) begin
            alert_line <= 1'b0;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    int unsigned rc;
    always_comb rc = chsel_r[0] ? 1 : 0;
    word_t rdv;
    always_comb begin
        rdv = 16'h0000;
        if (sh_r[7:0] == `CMD_CHSEL) rdv = {8'h00, chsel_r};
        else if (sh_r[7:0] == `CMD_OPER)  rdv = {8'h00, oper_r[rc]};
        else if (sh_r[7:0] == `CMD_ENSRC) rdv = {8'h00, ensrc_r};
        else if (sh_r[7:0] == `CMD_VFMT)  rdv = {8'h00, `VFMT_VAL};
        else if (sh_r[7:0] == `CMD_VTGT)  rdv = vtgt_r[rc];
        else if (sh_r[7:0] == `CMD_VTRIM) rdv = vtrim_r[rc];
        else if (sh_r[7:0] == `CMD_VMAX)  rdv = vmax_r[rc];
        else if (sh_r[7:0] == `CMD_VMHI)  rdv = vmhi_r[rc];
        else if (sh_r[7:0] == `CMD_VMLO)  rdv = vmlo_r[rc];
        else if (sh_r[7:0] == `CMD_SLEW)  rdv = slew_r[rc];
        else if (sh_r[7:0] == `CMD_SLOPE) rdv = slope_r[rc];
        else if (sh_r[7:0] == `CMD_FSW)   rdv = fsw_r[rc];
    end
    // load read word after cmd byte of a read frame; answered whether on or off
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rd_sh_r <= 16'h0000;
            lnk.sdo <= 1'b0;
        end else if (cs_act && bits_r == 5'd9 && sh_r[8] && scl_rise == 1'b0) begin
            // first bit goes out early so the host finds it at the next clock rise
            rd_sh_r <= busy_r ? 16'hffff : rdv;
            lnk.sdo <= busy_r ? 1'b1 : rdv[15];
        end else if (cs_act && scl_rise && bits_r >= 5'd9) begin
            lnk.sdo <= rd_sh_r[14];
            rd_sh_r <= {rd_sh_r[14:0], 1'b0};
        end
    end
    always_ff @(posedge core_clk) begin
        lnk.busy <= srst ? 1'b1 : (busy_r | ~strap_done_r);
    end
endmodule
`default_nettype wire

// [pmb_consts.svh]
// Behaviour
// - linear short: 5-bit exponent, 11-bit mantissa
// - linear unsigned: 16-bit mantissa, exponent -13
// - linear signed: 16-bit two's complement, exponent -13
// - host disables output before most setting writes
// - device may defer settings until re-enable
// - reads answered at any time; code returns ffffh during the save/load busy window
// - host waits 100ms after save or load
// - host spaces reads 2ms, other commands 5ms
// - channel select 00h, 01h, ffh both
// - operation codes off, soft off, on, margins
// - enable source 16h/17h pin, 1ah/1bh command
// - fault clear drops faults and alert line
// - save copies settings, busy 20ms
// - load restores settings at power-up, busy 20ms; code loads straps at power-up with no busy window, store lost on srst
// - host empties store by reload then save
// - output voltage format reads 13h always
// - target never above ceiling, strapped reset; code clamps target writes only, a lower ceiling write leaves target above it
// - signed trim offset added, reset 0000h
// - ceiling caps output, reset 1.10 strap
// - margins reset 1.05 and 0.95 strap
// - voltage changes ramp at slew rate; code steps 1 code per clock whatever the rate, 7fffh jumps
// - switching rate written only while disabled
`ifndef PMB_CONSTS_SVH
`define PMB_CONSTS_SVH
`define CMD_CHSEL       8'h00
`define CMD_OPER        8'h01
`define CMD_ENSRC       8'h02
`define CMD_CLRF        8'h03
`define CMD_SAVE        8'h15
`define CMD_LOAD        8'h16
`define CMD_VFMT        8'h20
`define CMD_VTGT        8'h21
`define CMD_VTRIM       8'h23
`define CMD_VMAX        8'h24
`define CMD_VMHI        8'h25
`define CMD_VMLO        8'h26
`define CMD_SLEW        8'h27
`define CMD_SLOPE       8'h28
`define CMD_FSW         8'h33
`define CH_ONE          8'h00
`define CH_TWO          8'h01
`define CH_BOTH         8'hff
`define OP_OFF_NOW      8'h00
`define OP_OFF_SOFT     8'h40
`define OP_ON_NOM       8'h80
`define OP_ON_LOW       8'h90
`define OP_ON_HIGH      8'ha0
`define SRC_PIN_SOFT    8'h16
`define SRC_PIN_NOW     8'h17
`define SRC_CMD_SOFT    8'h1a
`define SRC_CMD_NOW     8'h1b
`define VFMT_VAL        8'h13
`define TRIM_RST        16'h0000
`define SLEW_RST        16'hba00
`define SLEW_FAST       16'h7fff
`define BUSY_MS         20
`define CLK_PER_MS      250000
`define BUSY_CYC        (`BUSY_MS * `CLK_PER_MS)
`define SCL_DIV         8'd40
`define SLEW_STEP       16'h0001
`endif

// [pmb_pkg.sv]
package pmb_pkg;
    typedef enum logic [2:0] {
        L_IDLE = 3'b000,
        L_ADDR = 3'b001,
        L_WDAT = 3'b010,
        L_RDAT = 3'b011,
        L_DONE = 3'b100
    } link_state_e;
    typedef logic [15:0] word_t;
endpackage

// [pmb_if.sv]
`timescale 1ns/100ps
`default_nettype none
// serial frame link: host drives clock, select and data out; device answers on sdo
interface pmb_if;
    logic scl;
    logic cs;
    logic sdi;
    logic sdo;
    logic busy;
    modport host (output scl, output cs, output sdi, input sdo, input busy);
    modport dev  (input scl, input cs, input sdi, output sdo, output busy);
endinterface
`default_nettype wire

// [pmb_host.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pmb_consts.svh"
// software port: 0 cmd/rw, 1 data, 2 go (write), 3 read data; reads of 0-2 give status
module pmb_host
    import pmb_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        srst,
    pmb_if.host              lnk,
    input  wire logic [1:0]  sw_addr,
    input  wire logic [15:0] sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic      [15:0] sw_rdata
);
    logic [8:0]  cmd_r;
    word_t       dat_r, rx_r;
    logic [24:0] tx_r;
    logic [4:0]  cnt_r;
    logic [7:0]  div_r;
    link_state_e st_r;
    logic [1:0]  sdo_s_r, busy_s_r;
    always_ff @(posedge core_clk) begin
        sdo_s_r  <= {sdo_s_r[0], lnk.sdo};
        busy_s_r <= {busy_s_r[0], lnk.busy};
    end
    // software registers; spacing of commands is software's duty
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cmd_r <= 9'h000;
            dat_r <= 16'h0000;
        end else if (sw_wr && sw_addr == 2'd0) begin
            cmd_r <= sw_wdata[8:0];
        end else if (sw_wr && sw_addr == 2'd1) begin
            dat_r <= sw_wdata;
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sw_rdata <= 16'h0000;
        end else if (sw_rd && sw_addr == 2'd3) begin
            sw_rdata <= {rx_r[15:0]};
        end else if (sw_rd) begin
            sw_rdata <= {13'h0000, busy_s_r[1], st_r != L_IDLE, 1'b0};
        end
    end
    // frame engine, scl from divider
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_r    <= L_IDLE;
            lnk.scl <= 1'b0;
            lnk.cs  <= 1'b0;
            lnk.sdi <= 1'b0;
            div_r   <= 8'd0;
            cnt_r   <= 5'd0;
            rx_r    <= 16'h0000;
        end else begin
            case (st_r)
                L_IDLE: if (sw_wr && sw_addr == 2'd2 && !busy_s_r[1]) begin
                    tx_r  <= {cmd_r[8], cmd_r[7:0], dat_r};
                    cnt_r <= 5'd0;
                    div_r <= 8'd0;
                    lnk.cs <= 1'b1;
                    st_r  <= L_ADDR;
                end
                L_ADDR: begin
                    div_r <= div_r + 8'd1;
                    if (div_r == 8'd0) begin
                        lnk.sdi <= tx_r[24];
                        lnk.scl <= 1'b0;
                    end else if (div_r == `SCL_DIV / 8'd2) begin
                        lnk.scl <= 1'b1;
                        if (cnt_r >= 5'd9) rx_r <= {rx_r[14:0], sdo_s_r[1]};
                    end else if (div_r == `SCL_DIV) begin
                        div_r <= 8'd0;
                        tx_r  <= {tx_r[23:0], 1'b0};
                        cnt_r <= cnt_r + 5'd1;
                        if (cnt_r == 5'd24) st_r <= L_DONE;
                    end
                end
                L_DONE: begin
                    lnk.scl <= 1'b0;
                    lnk.cs  <= 1'b0;
                    st_r    <= L_IDLE;
                end
                default: st_r <= L_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// [pmb_link_chk.sv]
`timescale 1ns/100ps
`default_nettype none
// watches the serial link between the two ends
module pmb_link_chk (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic scl,
    input wire logic cs,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic busy
);
    localparam int FR_MIN = 600;
    localparam int FR_MAX = 1500;
    localparam int BSY_MAX = 60;
    logic [5:0] rise_cnt_r;

    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    // ****************************************
    // frame bookkeeping
    // ****************************************
    // counts clock rises of the running frame; cleared between frames
    always_ff @(posedge core_clk) begin
        if (srst || !cs) begin
            rise_cnt_r <= 6'h00;
        end else if ($rose(scl)) begin
            rise_cnt_r <= rise_cnt_r + 6'h01;
        end
    end

    sequence frame_open;
        $rose(cs);
    endsequence
    sequence frame_close;
        $fell(cs);
    endsequence

    // ****************************************
    // link rules
    // ****************************************
    frame_bits_a: assert property (frame_close |-> rise_cnt_r == 6'h19)
        else $error("frame did not carry 25 clock rises");
    frame_len_a: assert property (frame_open |-> ##[FR_MIN:FR_MAX] !cs)
        else $error("frame length out of bounds");
    clk_in_frame_a: assert property ($rose(scl) |-> cs)
        else $error("link clock rose outside a frame");
    clk_idle_a: assert property (!cs && !$past(cs) |-> $stable(scl))
        else $error("link clock moved between frames");
    clk_high_a: assert property ($rose(scl) |-> scl[*8])
        else $error("link clock high phase too short");
    clk_low_a: assert property ($fell(scl) && cs |-> !scl[*8])
        else $error("link clock low phase too short");
    data_hold_a: assert property (cs && scl && $past(scl) |-> $stable(sdi))
        else $error("host data moved while clock high");
    busy_len_a: assert property ($rose(busy) |-> ##[1:BSY_MAX] !busy)
        else $error("device busy window too long");
    busy_quiet_a: assert property ($rose(busy) |-> !cs)
        else $error("device went busy inside a frame");
endmodule
`default_nettype wire

// [pmbus_output_command_set_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module pmbus_output_command_set_tb;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic [1:0]  sw_addr = 2'h0;
    logic [15:0] sw_wdata = 16'h0000;
    logic        sw_wr = 1'b0;
    logic        sw_rd = 1'b0;
    logic [15:0] sw_rdata;
    logic        en_pin = 1'b0;
    logic        fault_in = 1'b0;
    logic [1:0]  out_on;
    logic [31:0] vout_set;
    logic        alert_line;
    logic        busy_seen = 1'b0;
    int          mismatches = 0;
    int          checks_done = 0;
    int          cycles = 0;

    pmb_if lnk_if();
    pmb_host pmb_host_inst (.core_clk(core_clk), .srst(srst), .lnk(lnk_if.host),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata));
    // short busy window keeps save and load cheap to simulate
    pmb_dev #(.BUSY_CYCLES(50)) pmb_dev_inst (.core_clk(core_clk), .srst(srst),
        .lnk(lnk_if.dev), .en_pin(en_pin), .fault_in(fault_in),
        .strap_vtgt(16'h2000), .strap_fsw(16'h0000), .out_on(out_on),
        .vout_set(vout_set), .alert_line(alert_line));
    pmb_link_chk pmb_link_chk_inst (.core_clk(core_clk), .srst(srst), .scl(lnk_if.scl),
        .cs(lnk_if.cs), .sdi(lnk_if.sdi), .sdo(lnk_if.sdo), .busy(lnk_if.busy));

    always #2 core_clk = ~core_clk;

    // ****************************************
    // timeout and busy watch
    // ****************************************
    // about 35 frames of 1k cycles each; the ceiling leaves over twice that
    always @(posedge core_clk) begin
        cycles++;
        if (lnk_if.busy === 1'b1) begin
            busy_seen <= 1'b1;
        end
        if (cycles == 90000) begin
            mismatches++;
            give_verdict();
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one strobe cycle on the software port
    task automatic sw_cyc(input logic wr, input logic [1:0] a, input logic [15:0] d);
        @(posedge core_clk);
        sw_wr <= wr;
        sw_rd <= !wr;
        sw_addr <= a;
        sw_wdata <= d;
        @(posedge core_clk);
        sw_wr <= 1'b0;
        sw_rd <= 1'b0;
    endtask

    // a whole frame: load, go, then wait out frame and busy window
    task automatic frame(input logic rw, input logic [7:0] cmd, input logic [15:0] d);
        int n;
        sw_cyc(1'b1, 2'h0, {7'h00, rw, cmd});
        sw_cyc(1'b1, 2'h1, d);
        sw_cyc(1'b1, 2'h2, 16'h0001);
        n = 0;
        while (lnk_if.cs !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        chk("frame start", 16'h0001, {15'h0000, lnk_if.cs});
        while (lnk_if.cs !== 1'b0 && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        // device busy shows only after sync, frame decode and its own flop
        repeat (10) @(posedge core_clk);
        while (lnk_if.busy !== 1'b0 && n < 3200) begin
            @(posedge core_clk);
            n++;
        end
        chk("frame end", 16'h0000, {15'h0000, lnk_if.cs});
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] cmd, input logic [15:0] exp);
        logic [15:0] got;
        frame(1'b1, cmd, 16'h0000);
        sw_cyc(1'b0, 2'h3, 16'h0000);
        #1 got = sw_rdata;
        chk(nm, exp, got);
    endtask

    function automatic logic [15:0] pick(input int sel);
        case (sel)
            0: return {15'h0000, out_on[0]};
            1: return vout_set[15:0];
            default: return {15'h0000, alert_line};
        endcase
    endfunction

    // 0 channel one on, 1 channel one output code, 2 alert line
    task automatic wait_chk(input string nm, input int sel, input logic [15:0] exp);
        int n;
        logic [15:0] got;
        n = 0;
        got = pick(sel);
        while (got !== exp && n < 3000) begin
            @(posedge core_clk);
            #1 got = pick(sel);
            n++;
        end
        chk(nm, exp, got);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rd_chk("format", 8'h20, 16'h0013);
        rd_chk("source", 8'h02, 16'h0017);
        rd_chk("select", 8'h00, 16'h0000);
        rd_chk("trim", 8'h23, 16'h0000);
        rd_chk("slew", 8'h27, 16'hba00);
    endtask

    task automatic t_pin();
        en_pin <= 1'b1;
        wait_chk("pin on", 0, 16'h0001);
        en_pin <= 1'b0;
        wait_chk("pin off", 0, 16'h0000);
    endtask

    task automatic t_oper();
        logic [7:0] codes [6] = '{8'h80, 8'h33, 8'h90, 8'ha0, 8'h40, 8'h00};
        logic       ons [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        frame(1'b0, 8'h02, 16'h001a);
        frame(1'b0, 8'h02, 16'h0055);
        rd_chk("bad source", 8'h02, 16'h001a);
        // the odd code 33h must leave the output running
        for (int i = 0; i < 6; i++) begin
            frame(1'b0, 8'h01, {8'h00, codes[i]});
            wait_chk("operation", 0, {15'h0000, ons[i]});
        end
    endtask

    task automatic t_volt();
        frame(1'b0, 8'h27, 16'h7fff);
        frame(1'b0, 8'h23, 16'h0010);
        frame(1'b0, 8'h21, 16'h1000);
        frame(1'b0, 8'h01, 16'h0080);
        wait_chk("nominal", 1, 16'h1010);
        frame(1'b0, 8'h25, 16'h1800);
        frame(1'b0, 8'h01, 16'h00a0);
        wait_chk("margin", 1, 16'h1810);
        frame(1'b0, 8'h24, 16'h1200);
        wait_chk("ceiling", 1, 16'h1200);
        frame(1'b0, 8'h21, 16'h1400);
        rd_chk("clamped", 8'h21, 16'h1200);
    endtask

    task automatic t_page();
        frame(1'b0, 8'h00, 16'h0001);
        frame(1'b0, 8'h23, 16'h0100);
        rd_chk("ch2 trim", 8'h23, 16'h0100);
        frame(1'b0, 8'h00, 16'h0000);
        rd_chk("ch1 trim", 8'h23, 16'h0010);
        frame(1'b0, 8'h00, 16'h0005);
        rd_chk("bad select", 8'h00, 16'h0000);
    endtask

    task automatic t_fault();
        fault_in <= 1'b1;
        wait_chk("alert", 2, 16'h0001);
        frame(1'b0, 8'h03, 16'h0000);
        wait_chk("fault held", 2, 16'h0001);
        fault_in <= 1'b0;
        frame(1'b0, 8'h03, 16'h0000);
        wait_chk("cleared", 2, 16'h0000);
    endtask

    task automatic t_store();
        busy_seen <= 1'b0;
        frame(1'b0, 8'h15, 16'h0000);
        chk("save busy", 16'h0001, {15'h0000, busy_seen});
        frame(1'b0, 8'h23, 16'h0020);
        frame(1'b0, 8'h16, 16'h0000);
        rd_chk("restored", 8'h23, 16'h0010);
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        repeat (10) @(posedge core_clk);
        t_reset();
        t_pin();
        t_oper();
        t_volt();
        t_page();
        t_fault();
        t_store();
        give_verdict();
    end
endmodule
`default_nettype wire
